// ### core/pulse_accum_pkg.sv
// Purpose: Shared constants and carrier types for the pulse accumulator
// Assumes: AXI4-Lite register access, 32-bit data, 100 MHz aclk
// Notes: Offsets are byte addresses derived from register indices
package pulse_accum_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] IDX_FLAGS = 8'h21;
  localparam logic [7:0] IDX_CONTROL = 8'h20;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h22;
  localparam logic [7:0] IDX_COUNT_LOW = 8'h23;
  localparam logic [7:0] IDX_TIMER_CTRL = 8'h24;
  localparam logic [7:0] IDX_STATUS = 8'h25;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTL_EN = 6;
  localparam int unsigned CTL_MODE = 5;
  localparam int unsigned CTL_EDGE = 4;
  localparam int unsigned CTL_CLK_HI = 3;
  localparam int unsigned CTL_CLK_LO = 2;
  localparam int unsigned CTL_OVI = 1;
  localparam int unsigned CTL_II = 0;
  localparam int unsigned FLG_OVF = 1;
  localparam int unsigned FLG_IF = 0;
  localparam int unsigned TSC_TEN = 7;
  localparam int unsigned TSC_FFCA = 4;

  // ----------------------------------------------------------------------
  // Reset values and divider constants
  // ----------------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
  localparam int unsigned GATE_DIV = 64;
  localparam logic [5:0] GATE_DIV_LAST = 6'(GATE_DIV - 1);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Counter clock selections
  localparam logic [1:0] CLK_PRESCALER = 2'h0;
  localparam logic [1:0] CLK_ACCUM = 2'h1;
  localparam logic [1:0] CLK_ACCUM_256 = 2'h2;
  localparam logic [1:0] CLK_ACCUM_64K = 2'h3;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_e;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] timer_ctrl;
    logic [15:0] count;
    logic ovf_flag;
    logic in_flag;
  } regs_s;

  typedef struct packed {
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
  } sync_s;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic aw_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_held;
    wr_state_e wr_state;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bus_s;

  typedef struct packed {
    logic [5:0] prescale;
    logic [15:0] accum_div;
    logic accum_clk;
    logic counter_clk;
    logic ovf_irq;
    logic in_irq;
  } outs_s;

  typedef struct packed {
    regs_s regs;
    sync_s sync;
    bus_s bus;
    outs_s outs;
  } state_s;

endpackage

// ### core/pulse_accum_unit.sv
// Purpose: 16-bit pulse accumulator with event and gated modes
// Assumes: channel7_pin asynchronous input; AXI4-Lite slave on aclk
// Notes: Main timer counter lives outside; this block hands it a clock
//
// What this block does
// - Accumulator enable independent of timer enable
// - Mode bit: 0 event, 1 gated
// - Mode and polarity act only when enabled
// - Event mode counts falling or rising edges
// - Gated mode counts tick; trailing edge flags
// - Gated tick needs the timer enabled
// - Clock select picks counter clock source
// - Disabled accumulator forces prescaler clock
// - Clock select change takes effect at once
// - Overflow enable gates overflow interrupt
// - Input enable gates input interrupt
// - Overflow flag set on count wrap
// - Writing one to bit 1 clears overflow
// - Input flag on counted or trailing edge
// - Writing one to bit 0 clears input flag
// - Fast clear: count access clears both flags
// - Count register readable, writable, counts edges or gated ticks
// - Pin synchronised before counting
// - Pin shared with timer channel 7
// - Interrupt outputs are active high
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns

module pulse_accum_unit (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address channel
  input wire logic [pulse_accum_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [pulse_accum_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Shared channel 7 pin, observed also by channel 7 capture logic
  input wire logic channel7_pin,
  // Timer counter clock enable pulse and interrupt requests
  output logic timer_count_tick,
  output logic accum_overflow_irq,
  output logic accum_input_irq
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Byte address of a register index
  function automatic logic [pulse_accum_pkg::ADDR_W-1:0] byte_addr(
    input logic [7:0] idx
  );
    byte_addr = pulse_accum_pkg::ADDR_W'({idx, 2'b00});
  endfunction

  // Index of a byte address, valid only when word aligned
  function automatic logic [7:0] addr_idx(
    input logic [pulse_accum_pkg::ADDR_W-1:0] a
  );
    addr_idx = {2'b00, a[pulse_accum_pkg::ADDR_W-1:2]};
  endfunction

  // Whether an index hits the count pair
  function automatic logic is_count(input logic [7:0] idx);
    is_count = (idx == pulse_accum_pkg::IDX_COUNT_HIGH) ||
               (idx == pulse_accum_pkg::IDX_COUNT_LOW);
  endfunction

  pulse_accum_pkg::state_s st_reg;
  pulse_accum_pkg::state_s st_next;

  // Working signals of the combinational process
  logic enabled;
  logic timer_enable_bit;
  logic rise;
  logic fall;
  logic count_event;
  logic input_event;
  logic gate_level;
  logic pre_tick;
  logic accum_pulse;
  logic div256_pulse;
  logic div64k_pulse;
  logic count_inc;
  logic do_write;
  logic do_read;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [7:0] wbyte;
  logic count_touch;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_val;
  logic [1:0] clk_sel;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // Whole block in one process so every effect of an edge is ordered
  always_comb begin
    st_next = st_reg;

    enabled = st_reg.regs.control[pulse_accum_pkg::CTL_EN];
    timer_enable_bit = st_reg.regs.timer_ctrl[pulse_accum_pkg::TSC_TEN];

    // Edge detection uses only the second stage and its delayed copy
    st_next.sync.pin_meta = channel7_pin;
    st_next.sync.pin_sync = st_reg.sync.pin_meta;
    st_next.sync.pin_prev = st_reg.sync.pin_sync;
    rise = st_reg.sync.pin_sync & ~st_reg.sync.pin_prev;
    fall = ~st_reg.sync.pin_sync & st_reg.sync.pin_prev;

    // Prescaler runs only with the timer on, so no /64 tick otherwise
    if (timer_enable_bit) begin
      st_next.outs.prescale = st_reg.outs.prescale + 6'd1;
    end else begin
      st_next.outs.prescale = '0;
    end
    pre_tick = timer_enable_bit &&
      (st_reg.outs.prescale == pulse_accum_pkg::GATE_DIV_LAST);

    // Mode and polarity are ignored while disabled
    count_event = 1'b0;
    input_event = 1'b0;
    gate_level = 1'b0;
    if (enabled) begin
      if (!st_reg.regs.control[pulse_accum_pkg::CTL_MODE]) begin
        // Event mode: polarity picks the counted edge
        count_event = st_reg.regs.control[pulse_accum_pkg::CTL_EDGE] ?
                      rise : fall;
        input_event = count_event;
      end else begin
        // Gated mode: active level lets the /64 tick through
        gate_level = st_reg.regs.control[pulse_accum_pkg::CTL_EDGE] ?
                     ~st_reg.sync.pin_sync : st_reg.sync.pin_sync;
        count_event = gate_level && pre_tick;
        input_event = st_reg.regs.control[pulse_accum_pkg::CTL_EDGE] ?
                      rise : fall;
      end
    end

    // Bus decode
    do_write = 1'b0;
    do_read = 1'b0;
    wr_idx = addr_idx(st_reg.bus.awaddr);
    rd_idx = addr_idx(s_axi_araddr);
    wbyte = st_reg.bus.wstrb[0] ? st_reg.bus.wdata[7:0] : 8'h00;
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    rd_val = '0;
    count_touch = 1'b0;

    // Capture write address and data in either order
    if (s_axi_awvalid && !st_reg.bus.aw_held) begin
      st_next.bus.awaddr = s_axi_awaddr;
      st_next.bus.aw_held = 1'b1;
    end
    if (s_axi_wvalid && !st_reg.bus.w_held) begin
      st_next.bus.wdata = s_axi_wdata;
      st_next.bus.wstrb = s_axi_wstrb;
      st_next.bus.w_held = 1'b1;
    end

    // Write execution once both halves are held
    case (st_reg.bus.wr_state)
      pulse_accum_pkg::WR_IDLE: begin
        if (st_reg.bus.aw_held && st_reg.bus.w_held) begin
          do_write = 1'b1;
          st_next.bus.aw_held = 1'b0;
          st_next.bus.w_held = 1'b0;
          st_next.bus.wr_state = pulse_accum_pkg::WR_RESP;
        end
      end
      pulse_accum_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          st_next.bus.wr_state = pulse_accum_pkg::WR_IDLE;
        end
      end
      default: begin
        st_next.bus.wr_state = pulse_accum_pkg::WR_IDLE;
      end
    endcase

    // Read accepted when no read data is pending
    if (s_axi_arvalid && !st_reg.bus.rvalid) begin
      do_read = 1'b1;
    end
    if (st_reg.bus.rvalid && s_axi_rready) begin
      st_next.bus.rvalid = 1'b0;
    end

    // Read mux; the whole count is returned in one word
    if (do_read) begin
      rd_hit = (s_axi_araddr[1:0] == 2'b00);
      case (rd_idx)
        pulse_accum_pkg::IDX_CONTROL: rd_val = {24'h0, st_reg.regs.control};
        pulse_accum_pkg::IDX_FLAGS: begin
          rd_val = {30'h0, st_reg.regs.ovf_flag, st_reg.regs.in_flag};
        end
        pulse_accum_pkg::IDX_COUNT_HIGH: begin
          rd_val = {16'h0, st_reg.regs.count};
        end
        pulse_accum_pkg::IDX_COUNT_LOW: begin
          rd_val = {24'h0, st_reg.regs.count[7:0]};
        end
        pulse_accum_pkg::IDX_TIMER_CTRL: begin
          rd_val = {24'h0, st_reg.regs.timer_ctrl};
        end
        pulse_accum_pkg::IDX_STATUS: begin
          rd_val = {29'h0, st_reg.sync.pin_sync, accum_overflow_irq,
                    accum_input_irq};
        end
        default: rd_hit = 1'b0;
      endcase
      st_next.bus.rvalid = 1'b1;
      st_next.bus.rdata = rd_hit ? rd_val : 32'h0000_0000;
      st_next.bus.rresp = rd_hit ? pulse_accum_pkg::RESP_OKAY :
                                   pulse_accum_pkg::RESP_SLVERR;
      count_touch = rd_hit && is_count(rd_idx);
    end

    // Count update: hardware increment, software write overrides
    count_inc = count_event;
    if (count_inc) begin
      st_next.regs.count = st_reg.regs.count + 16'd1;
    end

    // Misaligned writes are refused whole, so no register sees them
    if (do_write && st_reg.bus.awaddr[1:0] == 2'b00) begin
      wr_hit = 1'b1;
      case (wr_idx)
        pulse_accum_pkg::IDX_CONTROL: begin
          // Clock select takes effect on the very next cycle
          if (st_reg.bus.wstrb[0]) begin
            st_next.regs.control = {1'b0, wbyte[6:0]};
          end
        end
        pulse_accum_pkg::IDX_TIMER_CTRL: begin
          if (st_reg.bus.wstrb[0]) begin
            st_next.regs.timer_ctrl = wbyte;
          end
        end
        pulse_accum_pkg::IDX_COUNT_HIGH: begin
          // Word write loads the full count; byte lanes honoured
          if (st_reg.bus.wstrb[0]) begin
            st_next.regs.count[7:0] = st_reg.bus.wdata[7:0];
          end
          if (st_reg.bus.wstrb[1]) begin
            st_next.regs.count[15:8] = st_reg.bus.wdata[15:8];
          end
          count_touch = 1'b1;
        end
        pulse_accum_pkg::IDX_COUNT_LOW: begin
          if (st_reg.bus.wstrb[0]) begin
            st_next.regs.count[7:0] = wbyte;
          end
          count_touch = 1'b1;
        end
        pulse_accum_pkg::IDX_FLAGS: begin
          // Handled with the flag logic below
        end
        default: wr_hit = 1'b0;
      endcase
      st_next.bus.bresp = wr_hit ? pulse_accum_pkg::RESP_OKAY :
                                   pulse_accum_pkg::RESP_SLVERR;
    end else if (do_write) begin
      st_next.bus.bresp = pulse_accum_pkg::RESP_SLVERR;
    end

    // Flags: clears first, then hardware sets so a set is never lost
    if (do_write && wr_hit && wr_idx == pulse_accum_pkg::IDX_FLAGS) begin
      if (wbyte[pulse_accum_pkg::FLG_OVF]) begin
        st_next.regs.ovf_flag = 1'b0;
      end
      if (wbyte[pulse_accum_pkg::FLG_IF]) begin
        st_next.regs.in_flag = 1'b0;
      end
    end
    if (count_touch && st_reg.regs.timer_ctrl[pulse_accum_pkg::TSC_FFCA]) begin
      st_next.regs.ovf_flag = 1'b0;
      st_next.regs.in_flag = 1'b0;
    end
    if (count_inc && st_reg.regs.count == pulse_accum_pkg::COUNT_ALL_ONES) begin
      st_next.regs.ovf_flag = 1'b1;
    end
    if (input_event) begin
      st_next.regs.in_flag = 1'b1;
    end

    // Accumulator clock chain: /256 and /65536 from count events
    accum_pulse = count_event;
    if (accum_pulse) begin
      st_next.outs.accum_div = st_reg.outs.accum_div + 16'd1;
    end
    div256_pulse = accum_pulse && (st_reg.outs.accum_div[7:0] == 8'hFF);
    div64k_pulse = accum_pulse && (st_reg.outs.accum_div == 16'hFFFF);

    // Counter clock source; prescaler forced while disabled
    clk_sel = st_reg.regs.control[pulse_accum_pkg::CTL_CLK_HI:
                                  pulse_accum_pkg::CTL_CLK_LO];
    if (!enabled) begin
      st_next.outs.counter_clk = pre_tick;
    end else begin
      case (clk_sel)
        pulse_accum_pkg::CLK_PRESCALER: st_next.outs.counter_clk = pre_tick;
        pulse_accum_pkg::CLK_ACCUM: st_next.outs.counter_clk = accum_pulse;
        pulse_accum_pkg::CLK_ACCUM_256: begin
          st_next.outs.counter_clk = div256_pulse;
        end
        pulse_accum_pkg::CLK_ACCUM_64K: begin
          st_next.outs.counter_clk = div64k_pulse;
        end
        default: st_next.outs.counter_clk = pre_tick;
      endcase
    end
    st_next.outs.accum_clk = accum_pulse;

    // Interrupt requests follow the next flag values
    st_next.outs.ovf_irq = st_next.regs.ovf_flag &
      st_next.regs.control[pulse_accum_pkg::CTL_OVI];
    st_next.outs.in_irq = st_next.regs.in_flag &
      st_next.regs.control[pulse_accum_pkg::CTL_II];
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Synchronous reset clears every field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.regs.control <= pulse_accum_pkg::CONTROL_RESET;
      st_reg.regs.count <= pulse_accum_pkg::COUNT_RESET;
      st_reg.bus.wr_state <= pulse_accum_pkg::WR_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all straight from state flip-flops
  // ----------------------------------------------------------------------
  assign s_axi_awready = ~st_reg.bus.aw_held;
  assign s_axi_wready = ~st_reg.bus.w_held;
  assign s_axi_bvalid = (st_reg.bus.wr_state == pulse_accum_pkg::WR_RESP);
  assign s_axi_bresp = st_reg.bus.bresp;
  assign s_axi_arready = ~st_reg.bus.rvalid;
  assign s_axi_rvalid = st_reg.bus.rvalid;
  assign s_axi_rdata = st_reg.bus.rdata;
  assign s_axi_rresp = st_reg.bus.rresp;
  assign timer_count_tick = st_reg.outs.counter_clk;
  assign accum_overflow_irq = st_reg.outs.ovf_irq;
  assign accum_input_irq = st_reg.outs.in_irq;

endmodule

// ### verification/pulse_accum_monitor.sv
// Purpose: Port-level assertions for the pulse accumulator
// Assumes: One clock, synchronous active-low reset
// Notes: Helper ages bound how late an interrupt may follow its cause
`timescale 1ns/1ns
module pulse_accum_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Pin and interrupt
  input wire logic channel7_pin,
  input wire logic accum_input_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Ages since the last pin change and the last bus activity
  // ----------------------------------------------------------------
  // Saturating, so a long idle spell never wraps back into range
  logic pin_prev_reg;
  logic [3:0] pin_age_reg;
  logic [3:0] bus_age_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_reg <= 1'b0;
      pin_age_reg <= 4'hF;
      bus_age_reg <= 4'hF;
    end else begin
      pin_prev_reg <= channel7_pin;
      pin_age_reg <= (channel7_pin != pin_prev_reg) ? 4'h0 :
                     pin_age_reg + 4'(pin_age_reg != 4'hF);
      bus_age_reg <= (s_axi_awvalid || s_axi_arvalid || s_axi_bvalid ||
                      s_axi_rvalid) ? 4'h0 :
                     bus_age_reg + 4'(bus_age_reg != 4'hF);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=>
                     s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
                     $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped or changed before rready");
  read_latency_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  ar_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  read_done_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  write_done_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  err_data_a:
    assert property (s_axi_rvalid && s_axi_rresp != pulse_accum_pkg::RESP_OKAY
                     |-> s_axi_rresp == pulse_accum_pkg::RESP_SLVERR &&
                     s_axi_rdata == 32'h0)
    else $error("bad read response or data on error");
  irq_cause_a:
    assert property ($rose(accum_input_irq) |->
                     pin_age_reg <= 4'd6 || bus_age_reg <= 4'd6)
    else $error("input interrupt rose with no pin edge or access");
  irq_clear_a:
    assert property ($fell(accum_input_irq) |-> bus_age_reg <= 4'd6)
    else $error("input interrupt fell with no register access");
endmodule

bind pulse_accum_unit pulse_accum_monitor mon (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .channel7_pin, .accum_input_irq);

// ### verification/pulse_source.sv
// Purpose: External pulse source on the shared channel 7 pin
// Assumes: Bench asks for pulses of at least three bus clocks
// Notes: Idle level is low, as with a pull-down on the pin
`timescale 1ns/1ns
module pulse_source (
  // Clock
  input wire logic aclk,
  // Command from the bench
  input wire logic start,
  input wire logic [7:0] n_pulses,
  input wire logic [15:0] width,
  // Pin and status
  output logic channel7_pin,
  output logic busy
);
  // Each pulse: high for width cycles, then low for width cycles
  initial begin
    channel7_pin = 1'b0;
    busy = 1'b0;
  end
  always begin
    @(posedge aclk);
    if (start === 1'b1) begin
      busy <= 1'b1;
      for (int i = 0; i < n_pulses; i++) begin
        channel7_pin <= 1'b1;
        repeat (width) @(posedge aclk);
        channel7_pin <= 1'b0;
        repeat (width) @(posedge aclk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// ### verification/tb.sv
// Purpose: Self-checking bench for the pulse accumulator
// Assumes: AXI4-Lite master tasks, pulse source on the pin
// Notes: Gated counts allow one tick either way for prescaler phase
`timescale 1ns/1ns
module tb;
  localparam int LIMIT = 20000;
  localparam logic [7:0] A_CTL = 8'(pulse_accum_pkg::IDX_CONTROL * 4);
  localparam logic [7:0] A_FLG = 8'(pulse_accum_pkg::IDX_FLAGS * 4);
  localparam logic [7:0] A_CNT = 8'(pulse_accum_pkg::IDX_COUNT_HIGH * 4);
  localparam logic [7:0] A_TMR = 8'(pulse_accum_pkg::IDX_TIMER_CTRL * 4);
  logic aclk;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic start = 1'b0;
  logic [7:0] n_pulses = 8'h0;
  logic [15:0] width = 16'h0;
  logic [31:0] s_axi_rdata, rd, keep;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, channel7_pin, busy, timer_count_tick;
  logic accum_overflow_irq, accum_input_irq;
  int failures, checks, cycles, ticks, t0;

  pulse_accum_unit dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel7_pin,
    .timer_count_tick, .accum_overflow_irq, .accum_input_irq);
  pulse_source src (.aclk, .start, .n_pulses, .width, .channel7_pin,
    .busy);

  // Clock, tick counter and watchdog
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    // Non-blocking, so a test reading it at an edge sees a settled count
    ticks <= ticks + int'(timer_count_tick === 1'b1);
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      $display("CHECK FAILED at %0t: timeout", $time);
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && !aw_ok) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // Ready raised late on purpose, so the slave must hold its answer
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic pulse_go(input logic [7:0] n, input logic [15:0] w);
    @(posedge aclk);
    start <= 1'b1;
    n_pulses <= n;
    width <= w;
    @(posedge aclk);
    start <= 1'b0;
  endtask

  // Extra cycles let the synchroniser settle before any read
  task automatic pulse_wait();
    do @(posedge aclk); while (busy === 1'b1);
    repeat (6) @(posedge aclk);
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(A_CTL);
    check(rd, 32'h0);
    rd_reg(A_CNT);
    check(rd, 32'h0);
    rd_reg(8'hFC);
    check({30'h0, rs}, 32'(pulse_accum_pkg::RESP_SLVERR));
    wr(A_CNT + 8'h1, 32'hFFFF);
    check({30'h0, rs}, 32'(pulse_accum_pkg::RESP_SLVERR));
    wr(A_CNT + 8'h4, 32'hA5);
    check({30'h0, rs}, 32'h0);
    rd_reg(A_CNT);
    check(rd, 32'hA5);
    $display("test reset_and_map done");
    // Polarity set but accumulator off: pin is ignored
    wr(A_CTL, 32'h10);
    pulse_go(8'd2, 16'd4);
    pulse_wait();
    rd_reg(A_CNT);
    check(rd, 32'hA5);
    $display("test disabled done");
    // Mid-pulse read tells which edge counts; timer stays off
    for (int p = 0; p < 2; p++) begin
      wr(A_CTL, 32'h40 | 32'(p << 4));
      wr(A_CNT, 32'h0);
      pulse_go(8'd1, 16'd40);
      repeat (8) @(posedge aclk);
      rd_reg(A_CNT);
      check(rd, 32'(p));
      pulse_wait();
      rd_reg(A_CNT);
      check(rd, 32'h1);
      rd_reg(A_FLG);
      check(rd, 32'h1);
      check({31'h0, accum_input_irq}, 32'h0);
      wr(A_FLG, 32'h1);
      rd_reg(A_FLG);
      check(rd, 32'h0);
    end
    $display("test event_edges done");
    wr(A_CTL, 32'h43);
    wr(A_CNT, 32'hFFFF);
    pulse_go(8'd1, 16'd4);
    pulse_wait();
    rd_reg(A_CNT);
    check(rd, 32'h0);
    rd_reg(A_FLG);
    check(rd, 32'h3);
    check({31'h0, accum_overflow_irq}, 32'h1);
    check({31'h0, accum_input_irq}, 32'h1);
    rd_reg(8'(pulse_accum_pkg::IDX_STATUS * 4));
    check(rd, 32'h3);
    wr(A_FLG, 32'h1);
    rd_reg(A_FLG);
    check(rd, 32'h2);
    check({31'h0, accum_input_irq}, 32'h0);
    wr(A_FLG, 32'h2);
    rd_reg(A_FLG);
    check(rd, 32'h0);
    check({31'h0, accum_overflow_irq}, 32'h0);
    $display("test overflow done");
    wr(A_CTL, 32'h44);
    t0 = ticks;
    pulse_go(8'd4, 16'd4);
    pulse_wait();
    check(32'(ticks - t0), 32'h4);
    // Any 256 consecutive events hold exactly one /256 tick
    wr(A_CTL, 32'h48);
    t0 = ticks;
    pulse_go(8'd255, 16'd3);
    pulse_wait();
    pulse_go(8'd1, 16'd3);
    pulse_wait();
    check(32'(ticks - t0), 32'h1);
    $display("test clock_select done");
    wr(A_FLG, 32'h3);
    wr(A_TMR, 32'h10);
    pulse_go(8'd1, 16'd4);
    pulse_wait();
    rd_reg(A_FLG);
    check(rd, 32'h1);
    rd_reg(A_CNT);
    rd_reg(A_FLG);
    check(rd, 32'h0);
    $display("test fast_clear done");
    wr(A_TMR, 32'h80);
    wr(A_CTL, 32'h60);
    wr(A_CNT, 32'h0);
    pulse_go(8'd1, 16'd320);
    pulse_wait();
    rd_reg(A_CNT);
    keep = rd;
    check(32'(rd >= 4 && rd <= 6), 32'h1);
    rd_reg(A_FLG);
    check(rd, 32'h1);
    wr(A_TMR, 32'h0);
    pulse_go(8'd1, 16'd320);
    pulse_wait();
    rd_reg(A_CNT);
    check(rd, keep);
    $display("test gated done");
    // Disabled accumulator: select ignored, prescaler tick every 64
    wr(A_TMR, 32'h80);
    wr(A_CTL, 32'h04);
    t0 = ticks;
    repeat (640) @(posedge aclk);
    check(32'(ticks - t0), 32'hA);
    $display("test clock_force done");
    print_verdict();
  end
endmodule
